// File: design/fac_card_end.sv
// Card end: decodes and executes file, authentication and channel commands
// Function
// - Disable deactivates file, sets its life-cycle flag
// - Deactivated file refuses all but restore
// - P1 00 id, 08 path root, 09 path
// - Data is id, path or empty; P2 zero
// - Empty data with zero P1 P2: current file
// - Restore reactivates file, clears life-cycle flag
// - Restore only when its access condition holds
// - Successful restore makes target the current file
// - Failed restore keeps current file and directory
// - Terminal selects application before authentication
// - Authentication P1 zero means implied algorithm
// - P2 b8 scope, b7-b6 zero, ref 01-1F
// - Authentication P2 zero means implied key
// - Lc is challenge length, Le answer length
// - Channel 0 always open, never closed
// - Card picks the channel on open
// - Closed channel number becomes free again
// - P1 00 opens, 80 closes, others reserved
// - P2 zero auto-assign; 01-03 only close
// - One channel byte only for P1P2 0000
// - Channel commands carry no Lc or data
`timescale 1ns/1ns
module fac_card_end #(
    parameter int NFILE = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    fac_if.card link,
    input wire logic app_selected,
    input wire logic disable_ac_ok,
    input wire logic restore_ac_ok,
    input wire logic auth_done,
    input wire logic auth_ok,
    output logic auth_req,
    output logic auth_key_specific,
    output logic [4:0] auth_key_ref,
    output logic auth_implicit_alg,
    output logic auth_implicit_key,
    output logic [7:0] auth_len_in,
    output logic [7:0] auth_len_out,
    output logic [NFILE-1:0] file_off,
    output logic [15:0] cur_file,
    output logic [15:0] cur_dir,
    output logic [fac_pkg::FAC_NUM_CHAN-1:0] chan_open
);
    localparam int IW = $clog2(NFILE);

    fac_pkg::fac_card_state_type state_q, state_d;
    logic [NFILE-1:0] off_q, off_d;
    logic [15:0] cur_file_q, cur_file_d;
    logic [15:0] cur_dir_q;
    logic [15:0] sw_q, sw_d;
    logic [7:0] len_q, len_d;
    logic [7:0] byte_q, byte_d;
    logic req_q, req_d;
    logic spec_q, spec_d;
    logic [4:0] ref_q, ref_d;
    logic ialg_q, ialg_d;
    logic ikey_q, ikey_d;
    logic [7:0] lin_q, lin_d;
    logic [7:0] lout_q, lout_d;
    logic [fac_pkg::FAC_NUM_CHAN-1:0] ch_set, ch_clr;
    logic take;
    logic [15:0] target;
    logic [IW-1:0] idx;
    logic sel_ok, data_ok;
    logic [1:0] ch_free;

    assign take = link.cmd_valid && (state_q == fac_pkg::FAC_C_IDLE);
    assign link.cmd_ready = (state_q == fac_pkg::FAC_C_IDLE);
    assign link.rsp_valid = (state_q == fac_pkg::FAC_C_RESP);
    assign link.rsp_sw = sw_q;
    assign link.rsp_len = len_q;
    assign link.rsp_byte = byte_q;

    // Empty data field addresses the current file
    assign target = (link.cmd_lc == fac_pkg::FAC_LEN_EMPTY) ? cur_file_q : link.cmd_data;
    assign idx = target[IW-1:0];
    assign sel_ok = (link.cmd_p1 == fac_pkg::FAC_SEL_FID) ||
                    (link.cmd_p1 == fac_pkg::FAC_SEL_PATH_ROOT) ||
                    (link.cmd_p1 == fac_pkg::FAC_SEL_PATH_DIR);
    // Only the last path element is resolved; a path names a file id in this table
    always_comb begin
        data_ok = 1'b1;
        if (link.cmd_lc == fac_pkg::FAC_LEN_EMPTY) begin
            data_ok = (link.cmd_p1 == fac_pkg::FAC_SEL_FID);
        end else if (link.cmd_p1 == fac_pkg::FAC_SEL_FID) begin
            data_ok = (link.cmd_lc == fac_pkg::FAC_FID_LEN);
        end else begin
            data_ok = (link.cmd_lc >= fac_pkg::FAC_FID_LEN) && !link.cmd_lc[0];
        end
        if (target >= 16'(NFILE)) begin
            data_ok = 1'b0;
        end
    end

    // Lowest closed channel above the basic one
    always_comb begin
        ch_free = 2'd0;
        for (int i = fac_pkg::FAC_NUM_CHAN - 1; i >= 1; i--) begin
            if (!chan_open[i]) begin
                ch_free = 2'(i);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        off_d = off_q;
        cur_file_d = cur_file_q;
        sw_d = sw_q;
        len_d = len_q;
        byte_d = byte_q;
        req_d = 1'b0;
        spec_d = spec_q;
        ref_d = ref_q;
        ialg_d = ialg_q;
        ikey_d = ikey_q;
        lin_d = lin_q;
        lout_d = lout_q;
        ch_set = '0;
        ch_clr = '0;
        case (state_q)
            fac_pkg::FAC_C_IDLE: begin
                if (take) begin
                    state_d = fac_pkg::FAC_C_RESP;
                    len_d = 8'h00;
                    byte_d = 8'h00;
                    sw_d = fac_pkg::FAC_SW_OK;
                    case (link.cmd_kind)
                        fac_pkg::FAC_K_DISABLE, fac_pkg::FAC_K_RESTORE: begin
                            if (!sel_ok || link.cmd_p2 != fac_pkg::FAC_P2_ZERO ||
                                link.cmd_le_present) begin
                                sw_d = fac_pkg::FAC_SW_BAD_P1P2;
                            end else if (!data_ok) begin
                                sw_d = fac_pkg::FAC_SW_BAD_DATA;
                            end else if (link.cmd_kind == fac_pkg::FAC_K_DISABLE) begin
                                // Already deactivated file is refused a second disable
                                if (!disable_ac_ok || off_q[idx]) begin
                                    sw_d = fac_pkg::FAC_SW_REFUSED;
                                end else begin
                                    off_d[idx] = 1'b1;
                                    cur_file_d = target;
                                end
                            end else if (!restore_ac_ok) begin
                                sw_d = fac_pkg::FAC_SW_REFUSED;
                            end else begin
                                off_d[idx] = 1'b0;
                                cur_file_d = target;
                            end
                        end
                        fac_pkg::FAC_K_AUTH: begin
                            if (link.cmd_p1 != 8'h00 ||
                                link.cmd_p2[6:5] != fac_pkg::FAC_KEY_RSV_ZERO ||
                                (link.cmd_p2 != fac_pkg::FAC_P2_ZERO &&
                                 link.cmd_p2[4:0] < fac_pkg::FAC_KEY_REF_MIN)) begin
                                sw_d = fac_pkg::FAC_SW_BAD_P1P2;
                            end else if (!app_selected) begin
                                sw_d = fac_pkg::FAC_SW_REFUSED;
                            end else begin
                                state_d = fac_pkg::FAC_C_AUTH;
                                req_d = 1'b1;
                                ialg_d = (link.cmd_p1 == 8'h00);
                                ikey_d = (link.cmd_p2 == fac_pkg::FAC_P2_ZERO);
                                spec_d = link.cmd_p2[fac_pkg::FAC_KEY_SPEC_BIT];
                                ref_d = link.cmd_p2[4:0];
                                lin_d = link.cmd_lc;
                                lout_d = link.cmd_le_present ? link.cmd_le : 8'h00;
                            end
                        end
                        default: begin
                            if (link.cmd_lc != fac_pkg::FAC_LEN_EMPTY) begin
                                sw_d = fac_pkg::FAC_SW_BAD_DATA;
                            end else if (link.cmd_p1 == fac_pkg::FAC_CH_OPEN) begin
                                if (link.cmd_p2 != fac_pkg::FAC_P2_ZERO) begin
                                    sw_d = fac_pkg::FAC_SW_BAD_P1P2;
                                end else if (ch_free == 2'd0) begin
                                    sw_d = fac_pkg::FAC_SW_NO_CHAN;
                                end else begin
                                    ch_set[ch_free] = 1'b1;
                                    len_d = 8'h01;
                                    byte_d = {6'h00, ch_free};
                                end
                            end else if (link.cmd_p1 == fac_pkg::FAC_CH_CLOSE) begin
                                // Zero P2 would name the basic channel
                                if (link.cmd_p2 == fac_pkg::FAC_P2_ZERO ||
                                    link.cmd_p2 > fac_pkg::FAC_CH_MAX) begin
                                    sw_d = fac_pkg::FAC_SW_BAD_P1P2;
                                end else if (!chan_open[link.cmd_p2[1:0]]) begin
                                    sw_d = fac_pkg::FAC_SW_NO_CHAN;
                                end else begin
                                    ch_clr[link.cmd_p2[1:0]] = 1'b1;
                                end
                            end else begin
                                sw_d = fac_pkg::FAC_SW_BAD_P1P2;
                            end
                        end
                    endcase
                end
            end
            fac_pkg::FAC_C_AUTH: begin
                if (auth_done) begin
                    state_d = fac_pkg::FAC_C_RESP;
                    sw_d = auth_ok ? fac_pkg::FAC_SW_OK : fac_pkg::FAC_SW_AUTH_FAIL;
                    len_d = auth_ok ? lout_q : 8'h00;
                end
            end
            fac_pkg::FAC_C_RESP: begin
                state_d = fac_pkg::FAC_C_IDLE;
            end
            default: begin
                state_d = fac_pkg::FAC_C_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fac_pkg::FAC_C_IDLE;
            off_q <= '0;
            cur_file_q <= fac_pkg::FAC_CUR_FILE_RESET;
            cur_dir_q <= fac_pkg::FAC_CUR_FILE_RESET;
            sw_q <= fac_pkg::FAC_SW_OK;
            len_q <= 8'h00;
            byte_q <= 8'h00;
            req_q <= 1'b0;
            spec_q <= 1'b0;
            ref_q <= 5'h00;
            ialg_q <= 1'b0;
            ikey_q <= 1'b0;
            lin_q <= 8'h00;
            lout_q <= 8'h00;
        end else begin
            state_q <= state_d;
            off_q <= off_d;
            cur_file_q <= cur_file_d;
            cur_dir_q <= cur_dir_q;
            sw_q <= sw_d;
            len_q <= len_d;
            byte_q <= byte_d;
            req_q <= req_d;
            spec_q <= spec_d;
            ref_q <= ref_d;
            ialg_q <= ialg_d;
            ikey_q <= ikey_d;
            lin_q <= lin_d;
            lout_q <= lout_d;
        end
    end

    assign chan_open[0] = 1'b1;
    for (genvar g = 1; g < fac_pkg::FAC_NUM_CHAN; g++) begin : g_chan
        fac_chan_slot u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .open_set(ch_set[g]),
            .open_clr(ch_clr[g]),
            .is_open(chan_open[g])
        );
    end

    assign auth_req = req_q;
    assign auth_key_specific = spec_q;
    assign auth_key_ref = ref_q;
    assign auth_implicit_alg = ialg_q;
    assign auth_implicit_key = ikey_q;
    assign auth_len_in = lin_q;
    assign auth_len_out = lout_q;
    assign file_off = off_q;
    assign cur_file = cur_file_q;
    assign cur_dir = cur_dir_q;
endmodule // fac_card_end

// File: inc/fac_pkg.sv
// Shared constants and types for the file, authentication and channel command path
package fac_pkg;
    typedef enum logic [1:0] {
        FAC_K_DISABLE = 2'b00,
        FAC_K_RESTORE = 2'b01,
        FAC_K_AUTH = 2'b10,
        FAC_K_CHAN = 2'b11
    } fac_kind_type;

    typedef enum logic [1:0] {
        FAC_C_IDLE = 2'b00,
        FAC_C_AUTH = 2'b01,
        FAC_C_RESP = 2'b10
    } fac_card_state_type;

    typedef enum logic [1:0] {
        FAC_T_IDLE = 2'b00,
        FAC_T_SEND = 2'b01,
        FAC_T_WAIT = 2'b10
    } fac_term_state_type;

    // Selection byte of disable and restore
    localparam logic [7:0] FAC_SEL_FID = 8'h00;
    localparam logic [7:0] FAC_SEL_PATH_ROOT = 8'h08;
    localparam logic [7:0] FAC_SEL_PATH_DIR = 8'h09;
    localparam logic [7:0] FAC_P2_ZERO = 8'h00;
    localparam logic [7:0] FAC_LEN_EMPTY = 8'h00;
    localparam logic [7:0] FAC_FID_LEN = 8'h02;
    // Channel operation codes
    localparam logic [7:0] FAC_CH_OPEN = 8'h00;
    localparam logic [7:0] FAC_CH_CLOSE = 8'h80;
    localparam logic [7:0] FAC_CH_MAX = 8'h03;
    localparam int FAC_NUM_CHAN = 4;
    // Key reference field of the authentication P2
    localparam int FAC_KEY_SPEC_BIT = 7;
    localparam logic [1:0] FAC_KEY_RSV_ZERO = 2'h0;
    localparam logic [4:0] FAC_KEY_REF_MIN = 5'h01;
    localparam logic [15:0] FAC_CUR_FILE_RESET = 16'h0000;
    // Status words
    localparam logic [15:0] FAC_SW_OK = 16'h9000;
    localparam logic [15:0] FAC_SW_BAD_P1P2 = 16'h6b00;
    localparam logic [15:0] FAC_SW_BAD_DATA = 16'h6a80;
    localparam logic [15:0] FAC_SW_REFUSED = 16'h6985;
    localparam logic [15:0] FAC_SW_NO_CHAN = 16'h6a81;
    localparam logic [15:0] FAC_SW_AUTH_FAIL = 16'h6300;
    // Terminal APB register offsets
    localparam logic [7:0] FAC_OFF_CTRL = 8'h00;
    localparam logic [7:0] FAC_OFF_CMD = 8'h04;
    localparam logic [7:0] FAC_OFF_ARG = 8'h08;
    localparam logic [7:0] FAC_OFF_STAT = 8'h0c;
    localparam logic [7:0] FAC_OFF_RESP = 8'h10;
    // Field positions
    localparam int FAC_CTRL_GO = 0;
    localparam int FAC_CTRL_CLR = 1;
    localparam int FAC_CTRL_APP = 2;
    localparam int FAC_CMD_KIND_LSB = 0;
    localparam int FAC_CMD_LEP = 2;
    localparam int FAC_CMD_P1_LSB = 8;
    localparam int FAC_CMD_P2_LSB = 16;
    localparam int FAC_ARG_DATA_LSB = 0;
    localparam int FAC_ARG_LC_LSB = 16;
    localparam int FAC_ARG_LE_LSB = 24;
    localparam int FAC_STAT_BUSY = 0;
    localparam int FAC_STAT_DONE = 1;
    localparam int FAC_STAT_SW_LSB = 16;
    localparam int FAC_RESP_LEN_LSB = 8;
endpackage

// File: inc/fac_if.sv
// Command and response link between terminal end and card end
`timescale 1ns/1ns
interface fac_if;
    logic cmd_valid;
    logic cmd_ready;
    fac_pkg::fac_kind_type cmd_kind;
    logic [7:0] cmd_p1;
    logic [7:0] cmd_p2;
    logic [7:0] cmd_lc;
    logic [15:0] cmd_data;
    logic cmd_le_present;
    logic [7:0] cmd_le;
    logic rsp_valid;
    logic [15:0] rsp_sw;
    logic [7:0] rsp_len;
    logic [7:0] rsp_byte;

    modport card (
        input cmd_valid, cmd_kind, cmd_p1, cmd_p2, cmd_lc, cmd_data, cmd_le_present, cmd_le,
        output cmd_ready, rsp_valid, rsp_sw, rsp_len, rsp_byte
    );
    modport term (
        output cmd_valid, cmd_kind, cmd_p1, cmd_p2, cmd_lc, cmd_data, cmd_le_present, cmd_le,
        input cmd_ready, rsp_valid, rsp_sw, rsp_len, rsp_byte
    );
endinterface

// File: design/fac_chan_slot.sv
// Open flag of one logical channel
`timescale 1ns/1ns
module fac_chan_slot (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic open_set,
    input wire logic open_clr,
    output logic is_open
);
    logic open_q;
    logic open_d;

    always_comb begin
        open_d = open_q;
        if (open_clr) begin
            open_d = 1'b0;
        end
        if (open_set) begin
            open_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_q <= 1'b0;
        end else begin
            open_q <= open_d;
        end
    end

    assign is_open = open_q;
endmodule // fac_chan_slot

// File: design/fac_term_end.sv
// Terminal end: APB-programmed command issuer toward the card
`timescale 1ns/1ns
module fac_term_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fac_if.term link
);
    fac_pkg::fac_term_state_type state_q, state_d;
    logic [31:0] cmd_q, cmd_d;
    logic [31:0] arg_q, arg_d;
    logic app_q, app_d;
    logic done_q, done_d;
    logic [15:0] sw_q, sw_d;
    logic [7:0] rlen_q, rlen_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic wr, rd, hit;
    logic is_chan;
    fac_pkg::fac_kind_type kind;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign hit = (paddr == fac_pkg::FAC_OFF_CTRL) || (paddr == fac_pkg::FAC_OFF_CMD) ||
                 (paddr == fac_pkg::FAC_OFF_ARG) || (paddr == fac_pkg::FAC_OFF_STAT) ||
                 (paddr == fac_pkg::FAC_OFF_RESP);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign kind = fac_pkg::fac_kind_type'(cmd_q[fac_pkg::FAC_CMD_KIND_LSB +: 2]);
    assign is_chan = (kind == fac_pkg::FAC_K_CHAN);

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                fac_pkg::FAC_OFF_CTRL: prdata = {29'h0, app_q, 2'b00};
                fac_pkg::FAC_OFF_CMD: prdata = cmd_q;
                fac_pkg::FAC_OFF_ARG: prdata = arg_q;
                fac_pkg::FAC_OFF_STAT: prdata = {sw_q, 14'h0, done_q,
                                                 (state_q != fac_pkg::FAC_T_IDLE)};
                fac_pkg::FAC_OFF_RESP: prdata = {16'h0, rlen_q, rbyte_q};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        arg_d = arg_q;
        app_d = app_q;
        done_d = done_q;
        sw_d = sw_q;
        rlen_d = rlen_q;
        rbyte_d = rbyte_q;
        // Setup registers are frozen while a command is in flight
        if (wr && state_q == fac_pkg::FAC_T_IDLE) begin
            if (paddr == fac_pkg::FAC_OFF_CMD) begin
                cmd_d = pwdata;
            end
            if (paddr == fac_pkg::FAC_OFF_ARG) begin
                arg_d = pwdata;
            end
        end
        if (wr && paddr == fac_pkg::FAC_OFF_CTRL) begin
            app_d = pwdata[fac_pkg::FAC_CTRL_APP];
            if (pwdata[fac_pkg::FAC_CTRL_CLR]) begin
                done_d = 1'b0;
            end
        end
        case (state_q)
            fac_pkg::FAC_T_IDLE: begin
                if (wr && paddr == fac_pkg::FAC_OFF_CTRL && pwdata[fac_pkg::FAC_CTRL_GO]) begin
                    // No authentication without a selected application
                    if (kind == fac_pkg::FAC_K_AUTH && !pwdata[fac_pkg::FAC_CTRL_APP]) begin
                        sw_d = fac_pkg::FAC_SW_REFUSED;
                        rlen_d = 8'h00;
                        done_d = 1'b1;
                    end else begin
                        state_d = fac_pkg::FAC_T_SEND;
                        done_d = 1'b0;
                    end
                end
            end
            fac_pkg::FAC_T_SEND: begin
                if (link.cmd_ready) begin
                    state_d = fac_pkg::FAC_T_WAIT;
                end
            end
            fac_pkg::FAC_T_WAIT: begin
                if (link.rsp_valid) begin
                    state_d = fac_pkg::FAC_T_IDLE;
                    sw_d = link.rsp_sw;
                    rlen_d = link.rsp_len;
                    rbyte_d = link.rsp_byte;
                    done_d = 1'b1;
                end
            end
            default: begin
                state_d = fac_pkg::FAC_T_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fac_pkg::FAC_T_IDLE;
            cmd_q <= 32'h0000_0000;
            arg_q <= 32'h0000_0000;
            app_q <= 1'b0;
            done_q <= 1'b0;
            sw_q <= 16'h0000;
            rlen_q <= 8'h00;
            rbyte_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            arg_q <= arg_d;
            app_q <= app_d;
            done_q <= done_d;
            sw_q <= sw_d;
            rlen_q <= rlen_d;
            rbyte_q <= rbyte_d;
        end
    end

    assign link.cmd_valid = (state_q == fac_pkg::FAC_T_SEND);
    assign link.cmd_kind = kind;
    assign link.cmd_p1 = cmd_q[fac_pkg::FAC_CMD_P1_LSB +: 8];
    assign link.cmd_p2 = cmd_q[fac_pkg::FAC_CMD_P2_LSB +: 8];
    // Channel commands never carry Lc or data
    assign link.cmd_lc = is_chan ? 8'h00 : arg_q[fac_pkg::FAC_ARG_LC_LSB +: 8];
    assign link.cmd_data = is_chan ? 16'h0000 : arg_q[fac_pkg::FAC_ARG_DATA_LSB +: 16];
    assign link.cmd_le_present = cmd_q[fac_pkg::FAC_CMD_LEP];
    assign link.cmd_le = arg_q[fac_pkg::FAC_ARG_LE_LSB +: 8];
endmodule // fac_term_end

// File: bench/fac_assertions.sv
// Link protocol and decode checks between terminal end and card end
`timescale 1ns/1ns
module fac_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire fac_pkg::fac_kind_type cmd_kind,
    input wire logic [7:0] cmd_p1,
    input wire logic [7:0] cmd_p2,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_sw,
    input wire logic [7:0] rsp_len
);
    localparam logic [15:0] BAD = fac_pkg::FAC_SW_BAD_P1P2;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_file;
        s_take ##0 cmd_kind inside {fac_pkg::FAC_K_DISABLE, fac_pkg::FAC_K_RESTORE};
    endsequence
    sequence s_chan;
        s_take ##0 cmd_kind == fac_pkg::FAC_K_CHAN;
    endsequence
    property p_hold;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_p1) && $stable(cmd_p2);
    endproperty
    property p_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    property p_answer;
        s_take ##0 cmd_kind != fac_pkg::FAC_K_AUTH |=> rsp_valid && !cmd_ready;
    endproperty
    property p_sel;
        s_file ##0 !(cmd_p1 inside {8'h00, 8'h08, 8'h09}) |=> rsp_sw == BAD;
    endproperty
    property p_p2;
        s_file ##0 cmd_p2 != 8'h00 |=> rsp_sw == BAD;
    endproperty
    property p_rsv;
        s_chan ##0 !(cmd_p1 inside {8'h00, 8'h80}) |=> rsp_sw == BAD;
    endproperty
    property p_close0;
        s_chan ##0 cmd_p1 == 8'h80 && cmd_p2 == 8'h00 |=> rsp_sw == BAD;
    endproperty
    property p_nodata;
        s_chan ##0 {cmd_p1, cmd_p2} != 16'h0000 |=> rsp_len == 8'h00;
    endproperty
    property p_onebyte;
        s_chan ##0 {cmd_p1, cmd_p2} == 16'h0000 |=> rsp_len == {7'h0, rsp_sw == 16'h9000};
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while waiting");
    a_pulse: assert property (p_pulse) else $error("response longer than one cycle");
    a_answer: assert property (p_answer) else $error("no answer one cycle after take");
    a_sel: assert property (p_sel) else $error("reserved selection accepted");
    a_p2: assert property (p_p2) else $error("nonzero P2 accepted");
    a_rsv: assert property (p_rsv) else $error("reserved channel code accepted");
    a_close0: assert property (p_close0) else $error("basic channel closed");
    a_nodata: assert property (p_nodata) else $error("unexpected channel data");
    a_onebyte: assert property (p_onebyte) else $error("channel byte missing");
endmodule // fac_assertions

// File: bench/file_auth_channel_cmd_decoder_test.sv
// Self-checking bench: APB-driven terminal end facing card end
`timescale 1ns/1ns
module file_auth_channel_cmd_decoder_test;
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] arg;
        logic ac;
        logic [15:0] sw;
        logic [15:0] rsp;
        logic [15:0] cef;
    } fac_row_type;
    logic pclk, psel, penable, pwrite, pready, pslverr, err, ialg, ikey;
    logic presetn = 1'b0;
    logic ac_ok = 1'b1;
    logic auth_req;
    logic auth_done = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] file_off, lin, lout;
    logic [15:0] cur_file;
    logic [3:0] chan_open;
    int errors, n_tests;
    fac_row_type rows [21] = '{
        '{32'h0, 32'h20005, 1'b1, 16'h9000, 16'h0, 16'h5},
        '{32'h801, 32'h40005, 1'b1, 16'h9000, 16'h0, 16'h5},
        '{32'h0, 32'h20003, 1'b1, 16'h9000, 16'h0, 16'h3},
        '{32'h0, 32'h20003, 1'b1, 16'h6985, 16'h0, 16'h3},
        '{32'h101, 32'h20005, 1'b1, 16'h6b00, 16'h0, 16'h3},
        '{32'h10000, 32'h20005, 1'b1, 16'h6b00, 16'h0, 16'h3},
        '{32'h0, 32'h0, 1'b1, 16'h6985, 16'h0, 16'h3},
        '{32'h901, 32'h40005, 1'b0, 16'h6985, 16'h0, 16'h3},
        '{32'h901, 32'h40003, 1'b1, 16'h9000, 16'h0, 16'h3},
        '{32'h3, 32'h0, 1'b1, 16'h9000, 16'h101, 16'h3},
        '{32'h3, 32'h0, 1'b1, 16'h9000, 16'h102, 16'h3},
        '{32'h18003, 32'h0, 1'b1, 16'h9000, 16'h0, 16'h3},
        '{32'h3, 32'h0, 1'b1, 16'h9000, 16'h101, 16'h3},
        '{32'h3, 32'h0, 1'b1, 16'h9000, 16'h103, 16'h3},
        '{32'h3, 32'h0, 1'b1, 16'h6a81, 16'h0, 16'h3},
        '{32'h8003, 32'h0, 1'b1, 16'h6b00, 16'h0, 16'h3},
        '{32'h4003, 32'h0, 1'b1, 16'h6b00, 16'h0, 16'h3},
        '{32'h6, 32'h10080000, 1'b1, 16'h9000, 16'h1000, 16'h3},
        '{32'h200006, 32'h10080000, 1'b1, 16'h6b00, 16'h0, 16'h3},
        '{32'h6, 32'h10080000, 1'b0, 16'h6985, 16'h0, 16'h3},
        '{32'h0, 32'h0, 1'b1, 16'h9000, 16'h0, 16'h3}
    };
    fac_if link ();
    fac_term_end fac_term_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.term));
    fac_card_end fac_card_end_inst (.pclk(pclk), .presetn(presetn), .link(link.card),
        .app_selected(ac_ok), .disable_ac_ok(ac_ok), .restore_ac_ok(ac_ok),
        .auth_done(auth_done), .auth_ok(1'b1), .auth_req(auth_req), .auth_key_specific(),
        .auth_key_ref(), .auth_implicit_alg(ialg), .auth_implicit_key(ikey),
        .auth_len_in(lin), .auth_len_out(lout), .file_off(file_off), .cur_file(cur_file),
        .cur_dir(), .chan_open(chan_open));
    fac_assertions fac_assertions_inst (.pclk(pclk), .presetn(presetn),
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_kind(link.cmd_kind),
        .cmd_p1(link.cmd_p1), .cmd_p2(link.cmd_p2), .rsp_valid(link.rsp_valid),
        .rsp_sw(link.rsp_sw), .rsp_len(link.rsp_len));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Prompt authentication engine stand-in
    always @(posedge pclk) auth_done <= auth_req;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            errors++;
            conclude();
        end
    endtask
    task automatic run(input fac_row_type r);
        int n;
        ac_ok <= r.ac;
        apb(1'b1, 8'h08, r.arg);
        apb(1'b1, 8'h04, r.cmd);
        apb(1'b1, 8'h00, 32'h5);
        n = 0;
        do begin
            apb(1'b0, 8'h0c, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 30);
        if (n >= 30) begin
            errors++;
            conclude();
        end
        chk("sw", rd[31:16], r.sw);
        apb(1'b0, 8'h10, 32'h0);
        chk("len", rd[15:8], r.rsp[15:8]);
        if (r.rsp[15:8] == 8'h01) chk("chan", rd[7:0], r.rsp[7:0]);
        chk("cur_file", cur_file, r.cef);
        apb(1'b1, 8'h00, 32'h6);
        $display("row done cmd %h", r.cmd);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        chk("file_off", file_off, 8'h08);
        chk("auth_out", {ialg, ikey, lin, lout}, 18'h30810);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", err, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("chan_open", chan_open, 4'h1);
        chk("file_off", file_off, 8'h00);
        presetn <= 1'b1;
        run('{32'h3, 32'h0, 1'b1, 16'h9000, 16'h101, 16'h0});
        $display("reset test done");
        conclude();
    end
endmodule // file_auth_channel_cmd_decoder_test
